// >>> shared/vco_cfg_pkg.sv
// Purpose: constants for the calibration and detector configuration bank
// Assumes: 24-bit registers reached by 5-bit register address
// Notes: field positions and reset values of both registers
package vco_cfg_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 24;
    localparam logic [4:0] ADDR_CAL_CFG = 5'h0a;
    localparam logic [4:0] ADDR_PD_CFG = 5'h0b;
    localparam logic [4:0] ADDR_OSC_BAND = 5'h05;
    localparam logic [23:0] CAL_CFG_RESET = 24'h002205;
    localparam logic [23:0] PD_CFG_RESET = 24'h0f8061;
    // calibration register fields
    localparam int CAL_WIN_LSB = 0;
    localparam int CAL_RSV_LSB = 3;
    localparam int CAL_FORCE_BIT = 10;
    localparam int CAL_BYPASS_BIT = 11;
    localparam int CAL_SER_BLOCK_BIT = 12;
    localparam int CAL_DIV_LSB = 13;
    // detector register fields
    localparam int PD_DEL_LSB = 0;
    localparam int PD_UP_BIT = 5;
    localparam int PD_DN_BIT = 6;
    localparam int PD_SLIP_LSB = 7;
    localparam int PD_FUP_BIT = 9;
    localparam int PD_FDN_BIT = 10;
    localparam int PD_FMID_BIT = 11;
    localparam int PD_PW_LSB = 20;
    // calibration clock divide ratios, codes 1..3
    localparam int DIV_CODE1 = 4;
    localparam int DIV_CODE2 = 16;
    localparam int DIV_CODE3 = 32;
    localparam int DIV_CNT_W = 5;
    localparam int WIN_CNT_W = 9;
    // window length of the top code, which is not 2^7
    localparam int CAL_WIN_TOP = 256;
    localparam int BAND_W = 8;
endpackage

// >>> shared/cal_clk_if.sv
`timescale 1ns/1ps
// Purpose: carries divider select and tick between config and divider
// Assumes: single clock domain
// Notes: tick is a one-cycle enable pulse
interface cal_clk_if;
    logic [1:0] div_sel;
    logic tick;
    modport ctrl (output div_sel, input tick);
    modport div (input div_sel, output tick);
endinterface

// >>> hw/cal_clk_div.sv
`timescale 1ns/1ps
// Purpose: calibration clock divider from reference clock
// Assumes: a new select applies to the running count
// Notes: emits one-cycle ticks, not a derived clock
module cal_clk_div
    import vco_cfg_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // divider link
    cal_clk_if.div div_port
);
    logic [DIV_CNT_W-1:0] count;
    logic [DIV_CNT_W-1:0] last;

    always_comb
    begin
        unique case (div_port.div_sel)
            2'd0: last = '0;
            2'd1: last = DIV_CNT_W'(DIV_CODE1 - 1);
            2'd2: last = DIV_CNT_W'(DIV_CODE2 - 1);
            2'd3: last = DIV_CNT_W'(DIV_CODE3 - 1);
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            count <= '0;
            div_port.tick <= 1'b0;
        end
        else if (count >= last)
        begin
            count <= '0;
            div_port.tick <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
            div_port.tick <= 1'b0;
        end
    end
endmodule

// >>> hw/vco_cal_and_detector_config.sv
`timescale 1ns/1ps
// Purpose: register bank for band calibration and phase detector setup
// Assumes: host write/read strobes synchronous to i_ref_clk
// Notes: analog behaviour is out of scope; outputs are control levels

// Behaviour
// - window is 2^code divider cycles, 256 for code 7
// - force band uses stored band value
// - bypass bit keeps autocalibration from starting
// - serial block suppresses band register transfers
// - calibration tick from divided reference
// - detector reset delay from 3-bit field
// - up output only when enabled or forced up
// - down output only when enabled or forced down
// - slip guard threshold code drives injection
// - force-up holds pump up on
// - force-down holds pump down on
// - force-midrail drives pump midrail
// - divider pulse width from 2-bit field
module vco_cal_and_detector_config
    import vco_cfg_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // register port
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rvalid,
    // calibration control
    input wire logic i_cal_start,
    input wire logic i_cal_edge,
    input wire logic [BAND_W-1:0] i_cal_band,
    output logic o_cal_busy,
    output logic o_cal_done,
    output logic [BAND_W-1:0] o_band,
    output logic o_cal_tick,
    output logic o_osc_serial_load,
    // detector and pump control
    input wire logic i_det_up,
    input wire logic i_det_down,
    output logic o_pump_up,
    output logic o_pump_down,
    output logic o_pump_midrail,
    output logic [2:0] o_detector_reset_delay_sel,
    output logic [1:0] o_slip_guard_threshold,
    output logic o_slip_guard_inject,
    input wire logic i_phase_err_over,
    output logic [1:0] o_divider_pulse_width_sel
);
    typedef enum logic [1:0] {CAL_IDLE, CAL_MEASURE, CAL_FINISH} cal_state_e;

    logic [DATA_W-1:0] cal_cfg;
    logic [DATA_W-1:0] pd_cfg;
    logic [BAND_W-1:0] osc_band;
    cal_state_e cal_state;
    logic [WIN_CNT_W-1:0] win_count;
    logic [WIN_CNT_W-1:0] win_len;
    logic [BAND_W-1:0] cal_result;
    cal_clk_if clk_link ();

    function automatic logic hit(input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    assign clk_link.div_sel = cal_cfg[CAL_DIV_LSB +: 2];

    cal_clk_div u_div (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .div_port(clk_link.div)
    );

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cal_cfg <= CAL_CFG_RESET;
            pd_cfg <= PD_CFG_RESET;
        end
        else if (i_wr_en)
        begin
            if (hit(i_addr, ADDR_CAL_CFG))
                cal_cfg <= i_wdata;
            if (hit(i_addr, ADDR_PD_CFG))
                pd_cfg <= i_wdata;
        end
    end

    // band register write and serial transfer toward oscillator
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            osc_band <= '0;
            o_osc_serial_load <= 1'b0;
        end
        else
        begin
            o_osc_serial_load <= 1'b0;
            if (i_wr_en && hit(i_addr, ADDR_OSC_BAND))
            begin
                osc_band <= i_wdata[BAND_W-1:0];
                o_osc_serial_load <= !cal_cfg[CAL_SER_BLOCK_BIT];
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata <= '0;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_rd_en;
            if (!i_rd_en)
                o_rdata <= '0;
            else if (hit(i_addr, ADDR_CAL_CFG))
                o_rdata <= cal_cfg;
            else if (hit(i_addr, ADDR_PD_CFG))
                o_rdata <= pd_cfg;
            else if (hit(i_addr, ADDR_OSC_BAND))
                o_rdata <= DATA_W'(osc_band);
            else
                o_rdata <= '0;
        end
    end

    // window length 2^code
    // top code jumps past 128 straight to the longest window
    assign win_len = (cal_cfg[CAL_WIN_LSB +: 3] == 3'h7)
        ? WIN_CNT_W'(CAL_WIN_TOP)
        : WIN_CNT_W'(1) << cal_cfg[CAL_WIN_LSB +: 3];

    // calibration measures and finishes on divided ticks; start is taken on any cycle
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cal_state <= CAL_IDLE;
            win_count <= '0;
            cal_result <= '0;
            o_cal_done <= 1'b0;
        end
        else
        begin
            o_cal_done <= 1'b0;
            unique case (cal_state)
                CAL_IDLE:
                begin
                    if (i_cal_start && !cal_cfg[CAL_BYPASS_BIT])
                    begin
                        cal_state <= CAL_MEASURE;
                        win_count <= '0;
                    end
                end
                CAL_MEASURE:
                begin
                    if (clk_link.tick && i_cal_edge)
                    begin
                        if (win_count == win_len - 1'b1)
                            cal_state <= CAL_FINISH;
                        else
                            win_count <= win_count + 1'b1;
                    end
                end
                CAL_FINISH:
                begin
                    if (clk_link.tick)
                    begin
                        cal_result <= i_cal_band;
                        o_cal_done <= 1'b1;
                        cal_state <= CAL_IDLE;
                    end
                end
            endcase
        end
    end

    // output registers
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_cal_busy <= 1'b0;
            o_band <= '0;
            o_cal_tick <= 1'b0;
            o_pump_up <= 1'b0;
            o_pump_down <= 1'b0;
            o_pump_midrail <= 1'b0;
            o_detector_reset_delay_sel <= PD_CFG_RESET[2:0];
            o_slip_guard_threshold <= '0;
            o_slip_guard_inject <= 1'b0;
            o_divider_pulse_width_sel <= '0;
        end
        else
        begin
            o_cal_busy <= (cal_state != CAL_IDLE);
            o_cal_tick <= clk_link.tick;
            o_band <= cal_cfg[CAL_FORCE_BIT] ? osc_band : cal_result;
            o_pump_up <= (i_det_up && pd_cfg[PD_UP_BIT])
                || pd_cfg[PD_FUP_BIT];
            o_pump_down <= (i_det_down && pd_cfg[PD_DN_BIT])
                || pd_cfg[PD_FDN_BIT];
            o_pump_midrail <= pd_cfg[PD_FMID_BIT];
            o_detector_reset_delay_sel <= pd_cfg[PD_DEL_LSB +: 3];
            o_slip_guard_threshold <= pd_cfg[PD_SLIP_LSB +: 2];
            o_slip_guard_inject <= (pd_cfg[PD_SLIP_LSB +: 2] != 2'd0)
                && i_phase_err_over;
            o_divider_pulse_width_sel <= pd_cfg[PD_PW_LSB +: 2];
        end
    end
endmodule

// >>> test/cfg_host.sv
// Purpose: host model driving the register port
// Assumes: one-cycle strobes, answer one cycle after read
// Notes: write data line is inverted once released
`timescale 1ns/1ps
module cfg_host
    import vco_cfg_pkg::*;
(
    // bus
    input wire logic i_clk,
    input wire logic [DATA_W-1:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_wr,
    output logic o_rd,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = '0;
    task automatic put(input logic [4:0] a, input logic [23:0] d);
        @(posedge i_clk);
        #1 {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(posedge i_clk);
        #1 {o_wr, o_wdata} = {1'b0, ~d};
    endtask
    task automatic get(input logic [4:0] a, output logic [23:0] d);
        @(posedge i_clk);
        #1 {o_rd, o_addr} = {1'b1, a};
        @(posedge i_clk);
        #1 o_rd = 1'b0;
        d = i_rvalid ? i_rdata : 'x;
    endtask
endmodule

// >>> test/vco_cfg_monitor.sv
// Purpose: port checks for the config bank
// Assumes: one clock, async high reset
// Notes: sees top ports only
`timescale 1ns/1ps
module vco_cfg_monitor
    import vco_cfg_pkg::*;
(
    // watched ports
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_phase_err_over,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_cal_busy,
    input wire logic o_cal_done,
    input wire logic o_osc_serial_load,
    input wire logic o_slip_guard_inject,
    input wire logic o_pump_midrail,
    input wire logic [2:0] o_detector_reset_delay_sel,
    input wire logic [1:0] o_slip_guard_threshold,
    input wire logic [1:0] o_divider_pulse_width_sel
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    logic wb;
    assign wb = i_wr_en && i_addr == ADDR_OSC_BAND;
    a_read_answered:
        assert property (i_rd_en |=> o_rvalid) else $error("no answer");
    a_answer_cause:
        assert property (o_rvalid |-> $past(i_rd_en)) else $error("stray");
    a_idle_data_zero:
        assert property (!o_rvalid |-> o_rdata == '0) else $error("rdata");
    a_done_single:
        assert property (o_cal_done |=> !o_cal_done) else $error("done");
    a_done_after_busy:
        assert property (o_cal_done |-> o_cal_busy || $past(o_cal_busy))
        else $error("done without busy");
    a_load_cause:
        assert property (o_osc_serial_load |-> $past(wb) || $past(wb, 2))
        else $error("load without band write");
    a_inject_cause:
        assert property (o_slip_guard_inject |-> $past(i_phase_err_over)
            && o_slip_guard_threshold != 2'h0) else $error("inject");
    a_fields_hold:
        assert property (!i_wr_en ##1 !i_wr_en |=> $stable({o_pump_midrail,
            o_detector_reset_delay_sel, o_slip_guard_threshold,
            o_divider_pulse_width_sel})) else $error("field moved");
endmodule
bind vco_cal_and_detector_config vco_cfg_monitor u_mon (.*);

// >>> test/testbench.sv
// Purpose: self-checking bench for the config bank
// Assumes: host model drives the register port
// Notes: reference model is an array of words
`timescale 1ns/1ps
module testbench;
    import vco_cfg_pkg::*;
    logic i_ref_clk, i_rst, st, eg, du, dd, pe, wr, rd, rv, ld, tk, dn, bz;
    logic up, dw, mid, inj;
    logic [4:0] ad;
    logic [7:0] cb, bd;
    logic [23:0] wd, rdt, v, mdl [32];
    logic [2:0] dly;
    logic [1:0] thr, pw;
    logic [31:0] seed = 32'hd2a3;
    int err_total, tests_run, nld, t, b, c;
    vco_cal_and_detector_config i_dut (.i_ref_clk, .i_rst, .i_wr_en(wr),
        .i_rd_en(rd), .i_addr(ad), .i_wdata(wd), .o_rdata(rdt),
        .o_rvalid(rv), .i_cal_start(st), .i_cal_edge(eg), .i_cal_band(cb),
        .o_cal_busy(bz), .o_cal_done(dn), .o_band(bd), .o_cal_tick(tk),
        .o_osc_serial_load(ld), .i_det_up(du), .i_det_down(dd),
        .o_pump_up(up), .o_pump_down(dw), .o_pump_midrail(mid),
        .o_detector_reset_delay_sel(dly), .o_slip_guard_threshold(thr),
        .o_slip_guard_inject(inj), .i_phase_err_over(pe),
        .o_divider_pulse_width_sel(pw));
    cfg_host i_host (.i_clk(i_ref_clk), .i_rdata(rdt), .i_rvalid(rv),
        .o_wr(wr), .o_rd(rd), .o_addr(ad), .o_wdata(wd));
    initial
    begin
        i_ref_clk = 0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) nld += ld;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [23:0] s, input logic [23:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wrm(input logic [4:0] a, input logic [23:0] d);
        mdl[a] = (a == ADDR_OSC_BAND) ? {16'h0, d[7:0]} : d;
        i_host.put(a, d);
    endtask
    task automatic rdchk(input logic [4:0] a);
        i_host.get(a, v);
        chk(v, (a == ADDR_CAL_CFG || a == ADDR_PD_CFG || a == ADDR_OSC_BAND)
            ? mdl[a] : 24'h0);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic wait_for(input logic sel, output int n);
        n = 0;
        // look only at edges, so a pulse is never caught mid-cycle
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (((sel ? tk : dn) !== 1'b1) && n < 600);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #500000;
        err_total++;
        results;
    end
    initial
    begin
        {i_rst, st, eg, du, dd, pe, cb} = {6'h20, 8'h3c};
        mdl = '{default: 24'h0};
        mdl[ADDR_CAL_CFG] = CAL_CFG_RESET;
        mdl[ADDR_PD_CFG] = PD_CFG_RESET;
        ticks(16);
        i_rst = 0;
        foreach (mdl[a]) if (a >= 10 || a == 5) rdchk(5'(a));
        wrm(5'h1b, 24'hffffff);
        rdchk(5'h1b);
        rdchk(ADDR_PD_CFG);
        $display("test reset values done");
        repeat (16)
        begin
            seed = xs(seed);
            {du, dd, pe} = seed[31:29];
            wrm(ADDR_PD_CFG, seed[23:0]);
            ticks(1);
            v = mdl[ADDR_PD_CFG];
            chk({pw, dly, thr, mid, up, dw, inj}, {13'h0, v[21:20], v[2:0],
                v[8:7], v[11], du & v[5] | v[9], dd & v[6] | v[10],
                v[8:7] != 2'h0 && pe});
            rdchk(ADDR_PD_CFG);
        end
        $display("test detector fields done");
        for (b = 0; b < 2; b++)
        begin
            wrm(ADDR_CAL_CFG, 24'h002447 | 24'(b << 12));
            rdchk(ADDR_CAL_CFG);
            nld = 0;
            wrm(ADDR_OSC_BAND, 24'h5a + 24'(b));
            ticks(3);
            chk(24'(nld), 24'(1 - b));
            if (b == 0) chk(bd, 8'h5a);
            rdchk(ADDR_OSC_BAND);
        end
        $display("test forced band done");
        for (c = 0; c < 4; c++)
        begin
            wrm(ADDR_CAL_CFG, 24'h000040 | 24'(c << 13));
            // first tick may still come off the old count
            repeat (3) wait_for(1, t);
            chk(24'(t), 24'(c == 0 ? 1 : c == 1 ? DIV_CODE1 :
                c == 2 ? DIV_CODE2 : DIV_CODE3));
        end
        $display("test divider done");
        eg = 1;
        for (c = 0; c < 7; c++)
        begin
            wrm(ADDR_CAL_CFG, 24'h000040 |
                24'(c == 6 ? 24'h800 : (c == 5 ? 7 : c)));
            seed = xs(seed);
            cb = seed[7:0];
            st = 1;
            ticks(1);
            st = 0;
            ticks(1);
            chk(24'(bz), 24'(c < 6));
            wait_for(0, t);
            if (c < 6) chk(24'(t), 24'((c == 5 ? 256 : 1 << c) + 1));
            else chk(24'(t), 24'(600));
            ticks(3);
            if (c < 6) chk(bd, cb);
        end
        $display("test calibration done");
        results;
    end
endmodule
